// ==== shared/oslc_pkg.sv ====
// constants, types and decode helpers for the output ramp slew control block
package oslc_pkg;

    // master clock period
    localparam int CLK_PERIOD_NS = 50;

    // register map
    localparam logic [7:0] ADDR_RAMP_SLEW_CONFIG = 8'h03;

    // field positions inside ramp_slew_config
    localparam int RISE_LSB         = 4;
    localparam int FALLOFF_EN_BIT   = 3;
    localparam int FALL_LSB         = 0;

    // values after reset, normal and bus terminator mode
    localparam logic [2:0] RISE_RST      = 3'h1;
    localparam logic [2:0] RISE_RST_TERM = 3'h0;
    localparam logic [2:0] FALL_RST      = 3'h4;
    localparam logic [2:0] FALL_RST_TERM = 3'h3;
    localparam logic       FALLOFF_RST   = 1'b1;

    // reference resolution is 2.5 mV, one ramp step is 10 mV
    localparam int         VREF_W   = 12;
    localparam logic [11:0] STEP_LSB = 12'h004;

    // step duration per slew code, in ns (10 mV / rate)
    localparam int STEP_NS_0 = 200000; // 0.05 V/ms
    localparam int STEP_NS_1 = 100000; // 0.1 V/ms
    localparam int STEP_NS_2 = 50000;  // 0.2 V/ms
    localparam int STEP_NS_3 = 40000;  // 0.25 V/ms
    localparam int STEP_NS_4 = 20000;  // 0.5 V/ms
    localparam int STEP_NS_5 = 10000;  // 1.0 V/ms
    localparam int STEP_NS_6 = 5000;   // 2.0 V/ms

    // step duration in master clock cycles
    localparam int CNT_W = 12;
    localparam logic [11:0] STEP_CYC_0 = 12'(STEP_NS_0 / CLK_PERIOD_NS);
    localparam logic [11:0] STEP_CYC_1 = 12'(STEP_NS_1 / CLK_PERIOD_NS);
    localparam logic [11:0] STEP_CYC_2 = 12'(STEP_NS_2 / CLK_PERIOD_NS);
    localparam logic [11:0] STEP_CYC_3 = 12'(STEP_NS_3 / CLK_PERIOD_NS);
    localparam logic [11:0] STEP_CYC_4 = 12'(STEP_NS_4 / CLK_PERIOD_NS);
    localparam logic [11:0] STEP_CYC_5 = 12'(STEP_NS_5 / CLK_PERIOD_NS);
    localparam logic [11:0] STEP_CYC_6 = 12'(STEP_NS_6 / CLK_PERIOD_NS);

    // ramp states
    typedef enum logic [1:0] {
        S_IDLE,
        S_RISE,
        S_HOLD,
        S_FALL
    } oslc_state_t;

    // slew code to step period; reserved code 7 runs at the slowest rate
    function automatic logic [11:0] step_cycles(input logic [2:0] code);
        logic [11:0] cyc;
        cyc = STEP_CYC_0;
        unique case (code)
            3'h0: cyc = STEP_CYC_0;
            3'h1: cyc = STEP_CYC_1;
            3'h2: cyc = STEP_CYC_2;
            3'h3: cyc = STEP_CYC_3;
            3'h4: cyc = STEP_CYC_4;
            3'h5: cyc = STEP_CYC_5;
            3'h6: cyc = STEP_CYC_6;
            3'h7: cyc = STEP_CYC_0;
        endcase
        return cyc;
    endfunction

endpackage

// ==== shared/oslc_step_if.sv ====
// step timer carrier between the ramp controller and its divider
`timescale 1ns/100ps
interface oslc_step_if;
    logic        run;    // divider counting
    logic [11:0] period; // cycles per step
    logic        tick;   // one cycle per elapsed step

    modport ctrl  (output run, output period, input tick);
    modport timer (input run, input period, output tick);
endinterface

// ==== src/oslc_step_timer.sv ====
// master clock divider that times each ramp step
`timescale 1ns/100ps
module oslc_step_timer
    import oslc_pkg::*;
(
    input  wire logic   clk_i,   // master clock
    input  wire logic   rst_n_i, // synchronous reset, active low
    oslc_step_if.timer  step     // run, period and tick
);

    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] period_ff;
    logic             restart;

    // a new period (direction or code change) restarts the step count,
    // so the first step after a turn-around runs at the new rate
    assign restart = !step.run || (step.period != period_ff);

    // tick on the last cycle of each period while running
    assign step.tick = step.run && !restart
                    && (count_ff <= CNT_W'(1));

    // period seen on the previous edge
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            period_ff <= STEP_CYC_0;
        else
            period_ff <= step.period;
    end

    // down counter, reloaded whenever idle, restarted or a step ends
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            count_ff <= STEP_CYC_0;
        else if (restart || step.tick)
            count_ff <= step.period;
        else
            count_ff <= count_ff - CNT_W'(1);
    end

    // helper: cycles since the divider started or last ticked
    logic [CNT_W-1:0] gap_ff;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || restart || step.tick)
            gap_ff <= CNT_W'(1);
        else
            gap_ff <= gap_ff + CNT_W'(1);
    end

    // step length equals the selected period
    a_tick_period_exact: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (step.tick && $stable(step.period)) |-> gap_ff == step.period)
        else $error("step tick does not match period");

endmodule // oslc_step_timer

// ==== src/oslc_ramp_ctrl.sv ====
// output reference ramp controller with slew config register
`timescale 1ns/100ps
module oslc_ramp_ctrl
    import oslc_pkg::*;
(
    input  wire logic        MCLK_I,          // master clock, 20 MHz
    input  wire logic        RST_N_I,         // synchronous reset, low
    input  wire logic        TERM_MODE_I,     // bus terminator mode strap
    input  wire logic        REG_WR_I,        // register write strobe
    input  wire logic [7:0]  REG_ADDR_I,      // register address
    input  wire logic [7:0]  REG_WDATA_I,     // register write data
    output logic      [7:0]  REG_RDATA_O,     // register read data
    input  wire logic        ON_CMD_I,        // output on request, level
    input  wire logic [11:0] TARGET_I,        // setpoint, 2.5 mV units
    input  wire logic [11:0] PREBIAS_I,       // sensed output, 2.5 mV
    input  wire logic        OC_TRIP_I,       // overcurrent comparator
    output logic      [11:0] VREF_O,          // ramp reference
    output logic             SWITCH_EN_O,     // power stage switching
    output logic             OC_FAULT_O,      // overcurrent latched
    output logic             RAMP_BUSY_O,     // reference is stepping
    output logic             OFF_DONE_O       // turn-off interval end
);

    oslc_state_t      st_ff;
    logic [2:0]       rise_code_ff;
    logic [2:0]       fall_code_ff;
    logic             falloff_slew_enable_ff;
    logic [11:0]      vref_ff;
    logic             switch_en_ff;
    logic             oc_fault_ff;
    logic             off_done_ff;
    logic [7:0]       rdata_ff;
    logic             cfg_hit;
    logic             tick;
    logic             off_req;
    logic [11:0]      nxt_up;
    logic [11:0]      nxt_down;

    oslc_step_if step ();

    // step divider on the master clock
    oslc_step_timer u_step_timer (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .step    (step.timer)
    );

    assign cfg_hit = REG_ADDR_I == ADDR_RAMP_SLEW_CONFIG;
    assign tick    = step.tick;
    assign off_req = !ON_CMD_I && (st_ff == S_RISE || st_ff == S_HOLD);

    // divider runs only while ramping; each direction uses its own code
    assign step.run    = (st_ff == S_RISE) || (st_ff == S_FALL);
    assign step.period = (st_ff == S_FALL) ? step_cycles(fall_code_ff)
                                           : step_cycles(rise_code_ff);

    // next reference one step up or down, clamped at target or zero
    assign nxt_up   = (TARGET_I - vref_ff > STEP_LSB) ? vref_ff + STEP_LSB
                                                      : TARGET_I;
    assign nxt_down = (vref_ff > STEP_LSB) ? vref_ff - STEP_LSB
                                           : 12'h000;

    // slew configuration register, defaults depend on terminator strap
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
        begin
            rise_code_ff           <= TERM_MODE_I ? RISE_RST_TERM
                                                  : RISE_RST;
            fall_code_ff           <= TERM_MODE_I ? FALL_RST_TERM
                                                  : FALL_RST;
            falloff_slew_enable_ff <= FALLOFF_RST;
        end
        else if (REG_WR_I && cfg_hit)
        begin
            rise_code_ff           <= REG_WDATA_I[RISE_LSB+:3];
            fall_code_ff           <= REG_WDATA_I[FALL_LSB+:3];
            falloff_slew_enable_ff <= REG_WDATA_I[FALLOFF_EN_BIT];
        end
    end

    // registered read data; bit 7 and unmapped addresses read zero
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            rdata_ff <= 8'h00;
        else if (cfg_hit)
            rdata_ff <= {1'b0, rise_code_ff, falloff_slew_enable_ff,
                         fall_code_ff};
        else
            rdata_ff <= 8'h00;
    end

    // ramp sequencer: reference, state and switch enable
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
        begin
            st_ff        <= S_IDLE;
            vref_ff      <= 12'h000;
            switch_en_ff <= 1'b0;
        end
        else
        begin
            unique case (st_ff)
                S_IDLE:
                begin
                    vref_ff      <= 12'h000;
                    switch_en_ff <= 1'b0;
                    if (ON_CMD_I && !oc_fault_ff)
                        st_ff <= S_RISE;
                end
                S_RISE, S_HOLD:
                begin
                    if (switch_en_ff && OC_TRIP_I)
                    begin
                        st_ff        <= S_IDLE;
                        vref_ff      <= 12'h000;
                        switch_en_ff <= 1'b0;
                    end
                    else if (!ON_CMD_I && falloff_slew_enable_ff)
                        st_ff <= S_FALL;
                    else if (!ON_CMD_I)
                    begin
                        st_ff        <= S_IDLE;
                        vref_ff      <= 12'h000;
                        switch_en_ff <= 1'b0;
                    end
                    else
                    begin
                        if (vref_ff >= PREBIAS_I)
                            switch_en_ff <= 1'b1;
                        if (vref_ff >= TARGET_I)
                        begin
                            vref_ff <= TARGET_I;
                            st_ff   <= S_HOLD;
                        end
                        else
                        begin
                            st_ff <= S_RISE;
                            if (tick)
                                vref_ff <= nxt_up;
                        end
                    end
                end
                S_FALL:
                begin
                    if (ON_CMD_I)
                        st_ff <= S_RISE;
                    else if (vref_ff == 12'h000)
                    begin
                        st_ff        <= S_IDLE;
                        switch_en_ff <= 1'b0;
                    end
                    else if (tick)
                        vref_ff <= nxt_down;
                end
            endcase
        end
    end

    // overcurrent latch, cleared when the on request is withdrawn
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            oc_fault_ff <= 1'b0;
        else if ((st_ff == S_RISE || st_ff == S_HOLD)
                 && switch_en_ff && OC_TRIP_I)
            oc_fault_ff <= 1'b1;
        else if (!ON_CMD_I)
            oc_fault_ff <= 1'b0;
    end

    // end of turn-off interval: at zero when ramped, else at switch-off
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            off_done_ff <= 1'b0;
        else
            off_done_ff <= (off_req && !falloff_slew_enable_ff)
                        || (st_ff == S_FALL && !ON_CMD_I
                            && vref_ff == 12'h000);
    end

    // outputs
    assign REG_RDATA_O = rdata_ff;
    assign VREF_O      = vref_ff;
    assign SWITCH_EN_O = switch_en_ff;
    assign OC_FAULT_O  = oc_fault_ff;
    assign RAMP_BUSY_O = step.run;
    assign OFF_DONE_O  = off_done_ff;

    // turn-off request sequences
    sequence s_off_plain;
        off_req && !falloff_slew_enable_ff && !(switch_en_ff && OC_TRIP_I);
    endsequence

    sequence s_off_ramped;
        st_ff == S_FALL && !ON_CMD_I && vref_ff == 12'h000;
    endsequence

    a_reset_defaults: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        $rose(RST_N_I) |-> falloff_slew_enable_ff
            && rise_code_ff == ($past(TERM_MODE_I) ? 3'h0 : 3'h1)
            && fall_code_ff == ($past(TERM_MODE_I) ? 3'h3 : 3'h4))
        else $error("slew config not at reset default");

    a_rate_independent: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (st_ff == S_FALL) |-> step.period == step_cycles(fall_code_ff))
        else $error("falling ramp not using falling rate");

    a_rise_step_size: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (st_ff == S_RISE && tick && ON_CMD_I && !OC_TRIP_I
         && vref_ff < TARGET_I && $stable(TARGET_I))
        |=> vref_ff - $past(vref_ff) <= STEP_LSB && vref_ff > $past(vref_ff))
        else $error("rising step not one 10 mV increment");

    a_fall_step_size: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (st_ff == S_FALL && tick && !ON_CMD_I && vref_ff > STEP_LSB)
        |=> vref_ff == $past(vref_ff) - STEP_LSB)
        else $error("falling step not one 10 mV decrement");

    a_prebias_holdoff: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (st_ff == S_RISE && !switch_en_ff && vref_ff < PREBIAS_I)
        |=> !switch_en_ff)
        else $error("switching started below pre-bias level");

    a_oc_trip_rise: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        ((st_ff == S_RISE || st_ff == S_HOLD) && switch_en_ff && OC_TRIP_I)
        |=> oc_fault_ff && !switch_en_ff && st_ff == S_IDLE)
        else $error("overcurrent did not trip during rise");

    a_off_plain: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        s_off_plain |=> OFF_DONE_O && !switch_en_ff && vref_ff == 12'h000)
        else $error("unramped turn-off did not end at switch-off");

    a_off_ramped: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        s_off_ramped |=> OFF_DONE_O && st_ff == S_IDLE && !switch_en_ff)
        else $error("ramped turn-off did not end at zero");

    a_hold_target: assert property (
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (st_ff == S_HOLD && ON_CMD_I && !OC_TRIP_I && $stable(TARGET_I))
        |=> vref_ff == $past(TARGET_I) && !RAMP_BUSY_O)
        else $error("reference moved while holding target");

endmodule // oslc_ramp_ctrl

// ==== sim/oslc_mgr_model.sv ====
// power manager model: register writes and output on/off commands
`timescale 1ns/100ps
module oslc_mgr_model
(
    input  wire logic        clk_i,    // shared master clock
    output logic             wr_o,     // write strobe
    output logic      [7:0]  addr_o,   // register address
    output logic      [7:0]  wdata_o,  // write data
    output logic             on_o,     // output on request
    output logic      [11:0] target_o  // setpoint, 2.5 mV units
);
    // bus idle at time zero
    initial
    begin
        wr_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
        on_o = 1'b0;
        target_o = 12'h000;
    end

    // one write cycle; data is scrambled once the strobe drops
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(negedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask

    // address also selects read data
    task automatic select(input logic [7:0] a);
        @(negedge clk_i);
        addr_o <= a;
    endtask

    // output on or off with a setpoint
    task automatic command(input logic on, input logic [11:0] t);
        @(negedge clk_i);
        on_o <= on;
        target_o <= t;
    endtask
endmodule // oslc_mgr_model

// ==== sim/oslc_ramp_ctrl_tb.sv ====
// self-checking bench for the ramp controller with a manager model
`timescale 1ns/100ps
module oslc_ramp_ctrl_tb;
    import oslc_pkg::*;
    logic        mclk, rst_n, term_mode, reg_wr, on_cmd, oc_trip;
    logic        switch_en, oc_fault, busy, off_done;
    logic [7:0]  addr, wdata, rdata;
    logic [11:0] target, prebias, vref;
    int          bad_count, samples_checked, seed, cycles, model_cfg;
    int          c, tgt;
    // slope per code in 10 mV/ms; reserved code runs slowest
    int          rate [8] = '{5, 10, 20, 25, 50, 100, 200, 5};

    oslc_mgr_model MGR (.clk_i(mclk), .wr_o(reg_wr), .addr_o(addr),
        .wdata_o(wdata), .on_o(on_cmd), .target_o(target));

    oslc_ramp_ctrl DUT (.MCLK_I(mclk), .RST_N_I(rst_n),
        .TERM_MODE_I(term_mode), .REG_WR_I(reg_wr), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .ON_CMD_I(on_cmd),
        .TARGET_I(target), .PREBIAS_I(prebias), .OC_TRIP_I(oc_trip),
        .VREF_O(vref), .SWITCH_EN_O(switch_en), .OC_FAULT_O(oc_fault),
        .RAMP_BUSY_O(busy), .OFF_DONE_O(off_done));

    // shared master clock, 50 ns period
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // compare a ramp value or flag
    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // compare a register read
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        chk_val({4'h0, got}, {4'h0, exp});
    endtask

    // step period in clocks: 10 mV over the selected slope
    function automatic int per(input int code);
        return 20000 / rate[code & 7];
    endfunction

    task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
        MGR.select(a);
        repeat (2) @(negedge mclk);
        chk_reg(rdata, exp);
    endtask

    task automatic write_cfg(input logic [7:0] d);
        MGR.write_reg(ADDR_RAMP_SLEW_CONFIG, d);
        model_cfg = d & 8'h7f;
    endtask

    task automatic do_reset(input logic term);
        @(negedge mclk);
        rst_n = 1'b0;
        term_mode = term;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        model_cfg = (term ? 8'h00 : 8'h10) | 8'h08 | (term ? 3 : 4);
    endtask

    // follow the reference step by step against the model
    task automatic watch(input logic up, input int t, input int pre);
        int last, prev, cyc, steps, p, nxt;
        last = vref;
        prev = vref;
        cyc = 0;
        steps = 0;
        p = per(up ? model_cfg >> 4 : model_cfg);
        while (last != t && cyc < 5000)
        begin
            @(negedge mclk);
            cyc++;
            chk_val(12'(busy), 12'h001);
            if (up && pre != 0)
                chk_val(switch_en, 12'(prev >= pre));
            prev = vref;
            if (vref != last)
            begin
                nxt = up ? (last + 4 > t ? t : last + 4)
                         : (last < 4 ? 0 : last - 4);
                chk_val(vref, 12'(nxt));
                chk_val(12'(steps == 0 ? (cyc >= p && cyc <= p + 3)
                        : cyc == p), 12'h001);
                last = vref;
                cyc = 0;
                steps++;
            end
        end
        chk_val(vref, 12'(t));
    endtask

    // turn-off interval end: one pulse, reference at zero
    task automatic off_chk();
        int n;
        n = 0;
        while (off_done !== 1'b1 && n < 4)
        begin
            @(negedge mclk);
            n++;
        end
        chk_val(off_done, 12'h001);
        chk_val(vref, 12'h000);
        chk_val(switch_en, 12'h000);
        chk_val(12'(busy), 12'h000);
        @(negedge mclk);
        chk_val(off_done, 12'h000);
    endtask

    initial
    begin
        seed = 32'h765b;
        bad_count = 0;
        samples_checked = 0;
        cycles = 0;
        rst_n = 1'b0;
        term_mode = 1'b0;
        prebias = 12'h000;
        oc_trip = 1'b0;
        do_reset(1'b1);
        read_chk(ADDR_RAMP_SLEW_CONFIG, 8'(model_cfg));
        do_reset(1'b0);
        read_chk(ADDR_RAMP_SLEW_CONFIG, 8'(model_cfg));
        read_chk(8'h04, 8'h00);
        $display("test defaults done");
        // random writes; a write elsewhere must not disturb the config
        repeat (4)
        begin
            c = $random(seed);
            write_cfg(8'(c));
            MGR.write_reg(8'h04, ~8'(c));
            read_chk(ADDR_RAMP_SLEW_CONFIG, 8'(model_cfg));
        end
        $display("test register done");
        // every rising code, turn-off without ramp-down
        for (c = 0; c < 8; c++)
        begin
            write_cfg(8'((c << 4) | 6));
            MGR.command(1'b1, 12'h004);
            watch(1'b1, 4, 0);
            MGR.command(1'b0, 12'h004);
            off_chk();
        end
        $display("test rising codes done");
        // every falling code with ramp-down, rising at the fastest
        for (c = 0; c < 8; c++)
        begin
            write_cfg(8'(8'h68 | c));
            MGR.command(1'b1, 12'h004);
            watch(1'b1, 4, 0);
            MGR.command(1'b0, 12'h004);
            watch(1'b0, 0, 0);
            off_chk();
        end
        $display("test falling codes done");
        // several steps into a pre-biased output, last step clamped unless the target is 16 or 20
        write_cfg(8'h6e);
        tgt = 13 + ($random(seed) & 7);
        prebias = 12'h009;
        MGR.command(1'b1, 12'(tgt));
        watch(1'b1, tgt, 9);
        repeat (110) @(negedge mclk);
        chk_val(vref, 12'(tgt));
        chk_val(12'(busy), 12'h000);
        $display("test prebias done");
        // overcurrent while on, then the request is refused until cleared
        oc_trip = 1'b1;
        repeat (2) @(negedge mclk);
        chk_val(oc_fault, 12'h001);
        chk_val(vref, 12'h000);
        chk_val(switch_en, 12'h000);
        oc_trip = 1'b0;
        repeat (120) @(negedge mclk);
        chk_val(vref, 12'h000);
        MGR.command(1'b0, 12'(tgt));
        repeat (2) @(negedge mclk);
        chk_val(oc_fault, 12'h000);
        $display("test overcurrent done");
        report_and_stop();
    end
endmodule // oslc_ramp_ctrl_tb
